// *** rtl/erc_pkg.sv ***
// shared constants, modes and carrier structs of the embedded ram block
package erc_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 512;
  // single-port halves: the top address bit picks the half
  localparam int HALF_BIT = ADDR_W - 1;

  // ****************************************************************
  // clocking modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_INDEP  = 2'h0,
    MODE_IN_OUT = 2'h1,
    MODE_RD_WR  = 2'h2,
    MODE_SINGLE = 2'h3
  } erc_mode_type;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // controls of one register group: clock pulse, enable, clear
  typedef struct packed {
    logic tick;
    logic ce;
    logic clr;
  } erc_ctl_type;

  // input register group of one port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic              we;
    logic              rden;
    logic              go;
  } erc_in_regs_type;

  // output register groups of both ports
  typedef struct packed {
    logic [DATA_W-1:0] dout_a;
    logic [DATA_W-1:0] dout_b;
    logic              vld_a;
    logic              vld_b;
    logic              wr_done_a;
    logic              wr_done_b;
  } erc_out_regs_type;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam erc_ctl_type      CTL_IDLE       = '0;
  localparam erc_in_regs_type  IN_REGS_RESET  = '0;
  localparam erc_out_regs_type OUT_REGS_RESET = '0;
  localparam logic [DATA_W-1:0] DATA_CLEAR    = '0;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR    = '0;

endpackage

// *** rtl/erc_in_group.sv ***
// input register group of one ram port: address, data, write enable, read enable
`timescale 1ns/1ps
`default_nettype none
module erc_in_group
  import erc_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  // group controls
  input  wire erc_ctl_type      ctl_i,
  input  wire logic             keep_rden_i,
  // user side
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] din_i,
  input  wire logic             we_i,
  input  wire logic             rden_i,
  // registered group
  output erc_in_regs_type       q_o
);

  erc_in_regs_type state;
  erc_in_regs_type next_state;

  // ****************************************************************
  // capture
  // ****************************************************************
  always_comb begin
    next_state    = state;
    next_state.go = 1'b0;
    // R17: clear zeroes the group
    if (ctl_i.clr) begin
      next_state.addr = ADDR_CLEAR;
      next_state.din  = DATA_CLEAR;
      next_state.we   = 1'b0;
      // R12: read enable not cleared while keep_rden_i is high
      next_state.rden = keep_rden_i ? state.rden : 1'b0;
    // R16: enable low holds group
    end else if (ctl_i.tick && ctl_i.ce) begin
      next_state.addr = addr_i;
      next_state.din  = din_i;
      next_state.we   = we_i;
      next_state.rden = rden_i;
      next_state.go   = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= IN_REGS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign q_o = state;

endmodule
`default_nettype wire

// *** rtl/erc_mem.sv ***
// storage array with two access ports; never cleared
`timescale 1ns/1ps
`default_nettype none
module erc_mem
  import erc_pkg::*;
(
  // clock
  input  wire logic              core_clk_i,
  // port a
  input  wire logic              wr_a_i,
  input  wire logic [ADDR_W-1:0] addr_a_i,
  input  wire logic [DATA_W-1:0] din_a_i,
  output logic      [DATA_W-1:0] rd_a_o,
  // port b
  input  wire logic              wr_b_i,
  input  wire logic [ADDR_W-1:0] addr_b_i,
  input  wire logic [DATA_W-1:0] din_b_i,
  output logic      [DATA_W-1:0] rd_b_o
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic              b_loses;

  // same-address double write: port a wins, the result stays defined
  assign b_loses = wr_a_i && (addr_a_i == addr_b_i);

  always_ff @(posedge core_clk_i) begin
    if (wr_b_i && !b_loses) begin
      mem[addr_b_i] <= din_b_i;
    end
    if (wr_a_i) begin
      mem[addr_a_i] <= din_a_i;
    end
  end

  assign rd_a_o = mem[addr_a_i];
  assign rd_b_o = mem[addr_b_i];

endmodule
`default_nettype wire

// *** rtl/erc_ram_top.sv ***
// embedded ram block with selectable clocking modes and per-group enables and clears
//
// What this block does
// R1: true dual-port use offers independent clock mode, one clock per port.
// R2: independent mode: port a registers on clock a, port b on clock b.
// R3: independent mode: each port has its own enable and clear.
// R4: input/output clock mode works in true and simple dual-port use.
// R5: input/output mode: one clock drives data, write enable and address registers.
// R6: input/output mode: the other clock drives only output data registers.
// R7: input/output mode: separate enables and clears for input and output groups.
// R8: read/write mode is simple dual-port with a write and a read clock.
// R9: read/write mode: write clock registers write data, address, enable.
// R10: read/write mode: read clock registers read address, read enable, output.
// R11: read/write mode: each clock has its enable; both sides clearable.
// R12: simple dual-port: read enable register has no clear; all others do.
// R13: single-port mode: one port reads or writes per cycle, never both.
// R14: single-port mode holds two independent memories of 2K bits each.
// R15: write enable alone picks read or write on a true port.
// R16: disabled group keeps contents and commits no write.
// R17: clear zeroes affected registers at once; array contents stay.
`timescale 1ns/1ps
`default_nettype none
module erc_ram_top
  import erc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // configuration
  input  wire erc_mode_type      mode_i,
  input  wire logic              sdp_i,
  // the two block clocks, as one-cycle pulses of core_clk_i
  input  wire logic              tick_0_i,
  input  wire logic              tick_1_i,
  // clock enables
  input  wire logic              ce_a_in_i,
  input  wire logic              ce_a_out_i,
  input  wire logic              ce_b_in_i,
  input  wire logic              ce_b_out_i,
  // clears
  input  wire logic              clr_a_in_i,
  input  wire logic              clr_a_out_i,
  input  wire logic              clr_b_in_i,
  input  wire logic              clr_b_out_i,
  // port a user side
  input  wire logic [ADDR_W-1:0] addr_a_i,
  input  wire logic [DATA_W-1:0] din_a_i,
  input  wire logic              we_a_i,
  output logic      [DATA_W-1:0] dout_a_o,
  output logic                   vld_a_o,
  output logic                   wr_done_a_o,
  // port b user side
  input  wire logic [ADDR_W-1:0] addr_b_i,
  input  wire logic [DATA_W-1:0] din_b_i,
  input  wire logic              we_b_i,
  input  wire logic              rden_b_i,
  output logic      [DATA_W-1:0] dout_b_o,
  output logic                   vld_b_o,
  output logic                   wr_done_b_o
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic erc_ctl_type mk_ctl(input logic tick, input logic ce, input logic clr);
    erc_ctl_type c;
    c.tick = tick;
    c.ce   = ce;
    c.clr  = clr;
    return c;
  endfunction

  // forces an address into one half of the array
  function automatic logic [ADDR_W-1:0] to_half(input logic [ADDR_W-1:0] a, input logic upper);
    logic [ADDR_W-1:0] r;
    r           = a;
    r[HALF_BIT] = upper;
    return r;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  erc_ctl_type       ctl_a_in;
  erc_ctl_type       ctl_a_out;
  erc_ctl_type       ctl_b_in;
  erc_ctl_type       ctl_b_out;
  logic              sdp;
  logic [ADDR_W-1:0] addr_a_eff;
  logic [ADDR_W-1:0] addr_b_eff;
  logic              we_b_eff;
  erc_in_regs_type   a_q;
  erc_in_regs_type   b_q;
  logic              wr_a;
  logic              wr_b;
  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] rd_b;
  logic              rd_ok_a;
  logic              rd_ok_b;
  logic              ld_a;
  logic              ld_b;
  erc_out_regs_type  state;
  erc_out_regs_type  next_state;

  // ****************************************************************
  // clock routing per mode
  // ****************************************************************
  always_comb begin
    // R8: simple dual-port in read/write mode
    sdp       = (mode_i == MODE_RD_WR) || ((mode_i == MODE_IN_OUT) && sdp_i);
    ctl_a_in  = CTL_IDLE;
    ctl_a_out = CTL_IDLE;
    ctl_b_in  = CTL_IDLE;
    ctl_b_out = CTL_IDLE;
    case (mode_i)
      MODE_INDEP: begin
        // R1: one clock per port
        // R2: whole port a on tick 0, port b on tick 1
        // R3: one enable and clear per port
        ctl_a_in  = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_a_out = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_b_in  = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
        ctl_b_out = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
      end
      MODE_IN_OUT: begin
        // R4: true or simple dual-port
        // R5: input groups on tick 0
        // R6: output groups on tick 1
        // R7: separate enables and clears
        ctl_a_in  = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_a_out = mk_ctl(tick_1_i, ce_a_out_i, clr_a_out_i);
        ctl_b_in  = mk_ctl(tick_0_i, ce_b_in_i, clr_b_in_i);
        ctl_b_out = mk_ctl(tick_1_i, ce_b_out_i, clr_b_out_i);
      end
      MODE_RD_WR: begin
        // R9: write side on tick 0
        // R10: read side and output on tick 1
        // R11: one enable per clock, both sides clearable
        ctl_a_in  = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_b_in  = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
        ctl_b_out = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
      end
      default: begin
        // R14: two single-port memories, each on its own clock
        ctl_a_in  = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_a_out = mk_ctl(tick_0_i, ce_a_in_i, clr_a_in_i);
        ctl_b_in  = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
        ctl_b_out = mk_ctl(tick_1_i, ce_b_in_i, clr_b_in_i);
      end
    endcase
  end

  // ****************************************************************
  // user-side steering
  // ****************************************************************
  always_comb begin
    addr_a_eff = addr_a_i;
    addr_b_eff = addr_b_i;
    we_b_eff   = we_b_i;
    case (mode_i)
      MODE_IN_OUT: begin
        // simple dual-port: port b only reads
        if (sdp_i) begin
          we_b_eff = 1'b0;
        end
      end
      MODE_RD_WR: begin
        // port b is the read side and never writes
        we_b_eff = 1'b0;
      end
      MODE_SINGLE: begin
        // R14: halves of 2K bits each, no overlap
        // forcing the top address bit keeps each half private to its port
        addr_a_eff = to_half(addr_a_i, 1'b0);
        addr_b_eff = to_half(addr_b_i, 1'b1);
      end
      default: begin
        addr_a_eff = addr_a_i;
        addr_b_eff = addr_b_i;
      end
    endcase
  end

  // ****************************************************************
  // input register groups
  // ****************************************************************
  erc_in_group u_in_a (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ctl_i       (ctl_a_in),
    .keep_rden_i (1'b0),
    .addr_i      (addr_a_eff),
    .din_i       (din_a_i),
    .we_i        (we_a_i),
    .rden_i      (1'b0),
    .q_o         (a_q)
  );

  erc_in_group u_in_b (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ctl_i       (ctl_b_in),
    .keep_rden_i (sdp),
    .addr_i      (addr_b_eff),
    .din_i       (din_b_i),
    .we_i        (we_b_eff),
    .rden_i      (rden_b_i),
    .q_o         (b_q)
  );

  // ****************************************************************
  // array access
  // ****************************************************************
  // R16: commit only after an enabled capture
  // R15: write enable level picks the operation
  assign wr_a = a_q.go && a_q.we;
  assign wr_b = b_q.go && b_q.we;

  // R13: a port reading is never writing
  // R12: simple dual-port reads follow the captured read enable
  always_comb begin
    rd_ok_a = 1'b0;
    rd_ok_b = 1'b0;
    case (mode_i)
      MODE_INDEP: begin
        rd_ok_a = !a_q.we;
        rd_ok_b = !b_q.we;
      end
      MODE_IN_OUT: begin
        if (sdp_i) begin
          // port a only writes in simple dual-port
          rd_ok_b = b_q.rden;
        end else begin
          rd_ok_a = !a_q.we;
          rd_ok_b = !b_q.we;
        end
      end
      MODE_RD_WR: begin
        // the write side has no output register in use
        rd_ok_b = b_q.rden;
      end
      default: begin
        rd_ok_a = !a_q.we;
        rd_ok_b = !b_q.we;
      end
    endcase
  end

  erc_mem u_mem (
    .core_clk_i (core_clk_i),
    .wr_a_i     (wr_a),
    .addr_a_i   (a_q.addr),
    .din_a_i    (a_q.din),
    .rd_a_o     (rd_a),
    .wr_b_i     (wr_b),
    .addr_b_i   (b_q.addr),
    .din_b_i    (b_q.din),
    .rd_b_o     (rd_b)
  );

  // ****************************************************************
  // output register groups
  // ****************************************************************
  // R16: a disabled output group never loads
  assign ld_a = ctl_a_out.tick && ctl_a_out.ce && rd_ok_a;
  assign ld_b = ctl_b_out.tick && ctl_b_out.ce && rd_ok_b;

  always_comb begin
    next_state           = state;
    next_state.vld_a     = 1'b0;
    next_state.vld_b     = 1'b0;
    next_state.wr_done_a = wr_a;
    next_state.wr_done_b = wr_b;
    // R17: clear zeroes output group
    if (ctl_a_out.clr) begin
      next_state.dout_a = DATA_CLEAR;
    // R16: enable low holds output
    end else if (ld_a) begin
      next_state.dout_a = rd_a;
      next_state.vld_a  = 1'b1;
    end
    // R17: clear zeroes output group
    if (ctl_b_out.clr) begin
      next_state.dout_b = DATA_CLEAR;
    // R10: read clock loads output
    end else if (ld_b) begin
      next_state.dout_b = rd_b;
      next_state.vld_b  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= OUT_REGS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign dout_a_o    = state.dout_a;
  assign dout_b_o    = state.dout_b;
  assign vld_a_o     = state.vld_a;
  assign vld_b_o     = state.vld_b;
  assign wr_done_a_o = state.wr_done_a;
  assign wr_done_b_o = state.wr_done_b;

endmodule
`default_nettype wire

// *** testbench/erc_ram_chk.sv ***
// assertion checker for the embedded ram block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module erc_ram_chk
  import erc_pkg::*;
(
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  // controls
  input wire erc_mode_type      mode_i,
  input wire logic              tick_0_i,
  input wire logic              tick_1_i,
  input wire logic              ce_a_in_i,
  input wire logic              ce_a_out_i,
  input wire logic              clr_a_in_i,
  input wire logic              clr_a_out_i,
  input wire logic              clr_b_in_i,
  input wire logic              we_a_i,
  // outputs
  input wire logic [DATA_W-1:0] dout_a_o,
  input wire logic [DATA_W-1:0] dout_b_o,
  input wire logic              vld_a_o,
  input wire logic              wr_done_a_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // properties
  // ****************************************************************
  // a write taken with no clear in the commit cycle
  sequence s_wr_a;
    tick_0_i && ce_a_in_i && we_a_i && !clr_a_in_i ##1 !clr_a_in_i;
  endsequence
  property p_rst_zero;
    $fell(rst_i) |-> dout_a_o == DATA_CLEAR && dout_b_o == DATA_CLEAR && !vld_a_o;
  endproperty
  property p_wr_a;
    s_wr_a |=> wr_done_a_o;
  endproperty
  property p_vld_a_ind;
    mode_i == MODE_INDEP && vld_a_o |-> $past(tick_0_i && ce_a_in_i);
  endproperty
  property p_vld_a_io;
    mode_i == MODE_IN_OUT && vld_a_o |-> $past(tick_1_i && ce_a_out_i);
  endproperty
  property p_no_vld_a_rw;
    mode_i == MODE_RD_WR && $past(mode_i) == MODE_RD_WR |-> !vld_a_o;
  endproperty
  // no tick means no change: the register must not drift on idle edges
  property p_hold_a;
    mode_i == MODE_INDEP && !(tick_0_i && ce_a_in_i) && !clr_a_in_i |=> $stable(dout_a_o);
  endproperty
  property p_clr_a_out;
    mode_i == MODE_IN_OUT && clr_a_out_i |=> dout_a_o == DATA_CLEAR && !vld_a_o;
  endproperty
  property p_clr_b_in;
    mode_i == MODE_INDEP && clr_b_in_i |=> dout_b_o == DATA_CLEAR;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("outputs not zero after reset");
  a_wr_a: assert property (p_wr_a)
    else $error("write not committed");
  a_vld_a_ind: assert property (p_vld_a_ind)
    else $error("port a load without its tick");
  a_vld_a_io: assert property (p_vld_a_io)
    else $error("port a output load without output tick");
  a_no_vld_a_rw: assert property (p_no_vld_a_rw)
    else $error("port a output loaded in read write mode");
  a_hold_a: assert property (p_hold_a)
    else $error("port a output changed without tick");
  a_clr_a_out: assert property (p_clr_a_out)
    else $error("output clear ignored");
  a_clr_b_in: assert property (p_clr_b_in)
    else $error("port b clear ignored");
endmodule
bind erc_ram_top erc_ram_chk u_chk (
  .core_clk_i, .rst_i, .mode_i, .tick_0_i, .tick_1_i, .ce_a_in_i, .ce_a_out_i,
  .clr_a_in_i, .clr_a_out_i, .clr_b_in_i, .we_a_i, .dout_a_o, .dout_b_o,
  .vld_a_o, .wr_done_a_o
);
`default_nettype wire

// *** testbench/erc_fab_ticks.sv ***
// fabric-side source of the two block clocks as pulses at unrelated rates
`timescale 1ns/1ps
`default_nettype none
module erc_fab_ticks #(
  parameter int P0 = 3,
  parameter int P1 = 5
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // block clocks
  output logic      tick_0_o,
  output logic      tick_1_o
);
  int c0;
  int c1;
  // different periods so input and output clocks never stay aligned
  always_ff @(posedge core_clk_i) begin
    c0       <= (rst_i || c0 == P0 - 1) ? 0 : c0 + 1;
    c1       <= (rst_i || c1 == P1 - 1) ? 0 : c1 + 1;
    tick_0_o <= !rst_i && c0 == P0 - 1;
    tick_1_o <= !rst_i && c1 == P1 - 1;
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench of the embedded ram block in all clocking modes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import erc_pkg::*;
  logic              core_clk_i, rst_i, sdp_i, tick_0_i, tick_1_i;
  erc_mode_type      mode_i;
  logic              ce_a_in_i, ce_a_out_i, ce_b_in_i, ce_b_out_i;
  logic              clr_a_in_i, clr_a_out_i, clr_b_in_i, clr_b_out_i;
  logic [ADDR_W-1:0] addr_a_i, addr_b_i;
  logic [DATA_W-1:0] din_a_i, din_b_i, dout_a_o, dout_b_o;
  logic              we_a_i, we_b_i, rden_b_i;
  logic              vld_a_o, vld_b_o, wr_done_a_o, wr_done_b_o;
  int                fail_count, n_checks, cyc;
  erc_fab_ticks u_fab (.core_clk_i, .rst_i, .tick_0_o(tick_0_i), .tick_1_o(tick_1_i));
  erc_ram_top dut (
    .core_clk_i, .rst_i, .mode_i, .sdp_i, .tick_0_i, .tick_1_i,
    .ce_a_in_i, .ce_a_out_i, .ce_b_in_i, .ce_b_out_i,
    .clr_a_in_i, .clr_a_out_i, .clr_b_in_i, .clr_b_out_i,
    .addr_a_i, .din_a_i, .we_a_i, .dout_a_o, .vld_a_o, .wr_done_a_o,
    .addr_b_i, .din_b_i, .we_b_i, .rden_b_i, .dout_b_o, .vld_b_o, .wr_done_b_o
  );
  // ****************************************************************
  // tasks
  // ****************************************************************
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] e);
    n_checks++;
    if (seen !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, seen);
    end
  endtask
  function automatic logic tk(input logic p);
    return (p && mode_i != MODE_IN_OUT) ? tick_1_i : tick_0_i;
  endfunction
  // hold the request until the port's input tick is sampled
  task acc(input logic p, input logic w, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] wd_exp;
    if (p) begin
      addr_b_i <= a;
      din_b_i  <= d;
      we_b_i   <= w;
      rden_b_i <= !w;
    end else begin
      addr_a_i <= a;
      din_a_i  <= d;
      we_a_i   <= w;
    end
    @(posedge core_clk_i);
    for (int i = 0; i < 12 && !tk(p); i++) @(posedge core_clk_i);
    if (p) begin
      we_b_i <= 1'b0;
    end else begin
      we_a_i <= 1'b0;
    end
    // a write lands one edge after capture, and wr_done is set at that same edge
    wd_exp = {7'h00, w && (p ? ce_b_in_i : ce_a_in_i)};
    repeat (2) @(posedge core_clk_i);
    chk("wr_done", {7'h00, p ? wr_done_b_o : wr_done_a_o}, wd_exp);
  endtask
  // the first load after capture may be stale, so skip two edges
  task rd(input logic p, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    acc(p, 1'b0, a, 8'h00);
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < 12 && !(p ? vld_b_o : vld_a_o); i++) @(posedge core_clk_i);
    chk("vld", {7'h00, p ? vld_b_o : vld_a_o}, 8'h01);
    chk(p ? "dout_b" : "dout_a", p ? dout_b_o : dout_a_o, e);
  endtask
  // modes change only while every group is disabled
  task md(input erc_mode_type m, input logic s);
    {ce_a_in_i, ce_a_out_i, ce_b_in_i, ce_b_out_i} <= 4'h0;
    repeat (7) @(posedge core_clk_i);
    mode_i <= m;
    sdp_i  <= s;
    @(posedge core_clk_i);
    {ce_a_in_i, ce_a_out_i, ce_b_in_i, ce_b_out_i} <= 4'hF;
    @(posedge core_clk_i);
  endtask
  // ****************************************************************
  // clock, timeout, sequence
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = !core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_i, sdp_i} = 2'h2;
    mode_i = MODE_INDEP;
    {ce_a_in_i, ce_a_out_i, ce_b_in_i, ce_b_out_i} = 4'h0;
    {clr_a_in_i, clr_a_out_i, clr_b_in_i, clr_b_out_i} = 4'h0;
    {addr_a_i, addr_b_i, din_a_i, din_b_i} = '0;
    {we_a_i, we_b_i, rden_b_i} = 3'h0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    md(MODE_INDEP, 1'b0);
    acc(1'b0, 1'b1, 9'h005, 8'hA5);
    acc(1'b1, 1'b1, 9'h1FF, 8'h3C);
    rd(1'b0, 9'h1FF, 8'h3C);
    rd(1'b1, 9'h005, 8'hA5);
    ce_a_in_i <= 1'b0;
    acc(1'b0, 1'b1, 9'h005, 8'h00);
    ce_a_in_i <= 1'b1;
    rd(1'b0, 9'h005, 8'hA5);
    clr_a_in_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    clr_a_in_i <= 1'b0;
    chk("dout_a", dout_a_o, 8'h00);
    chk("dout_b", dout_b_o, 8'hA5);
    rd(1'b0, 9'h005, 8'hA5);
    clr_b_in_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    clr_b_in_i <= 1'b0;
    chk("dout_b", dout_b_o, 8'h00);
    md(MODE_IN_OUT, 1'b0);
    rd(1'b0, 9'h1FF, 8'h3C);
    clr_a_out_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    clr_a_out_i <= 1'b0;
    chk("dout_a", dout_a_o, 8'h00);
    md(MODE_IN_OUT, 1'b1);
    acc(1'b0, 1'b1, 9'h010, 8'h5A);
    rd(1'b1, 9'h010, 8'h5A);
    clr_b_out_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    clr_b_out_i <= 1'b0;
    chk("dout_b", dout_b_o, 8'h00);
    md(MODE_RD_WR, 1'b1);
    acc(1'b0, 1'b1, 9'h020, 8'h77);
    rd(1'b1, 9'h020, 8'h77);
    md(MODE_SINGLE, 1'b0);
    acc(1'b0, 1'b1, 9'h0F0, 8'h11);
    acc(1'b1, 1'b1, 9'h0F0, 8'h22);
    rd(1'b0, 9'h1F0, 8'h11);
    rd(1'b1, 9'h0F0, 8'h22);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    chk("dout_b", dout_b_o, 8'h00);
    rd(1'b0, 9'h0F0, 8'h11);
    test_done();
  end
endmodule
`default_nettype wire
